// File: inc/mpw_pkg.sv
// ==========================================================================
// shared constants for the multiphase phase and mode controller
// ==========================================================================
package mpw_pkg;

	// clock rate and time figures
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESET_TIME_NS = 50000;
	localparam int MASK_TIME_NS = 100000;
	// least time rounds up; long mask count becomes a top parameter
	localparam int RESET_CYC = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MASK_CYC_DEF = MASK_TIME_NS / CLK_PERIOD_NS;
	localparam int DETECT_TICKS = 3;

	// register byte offsets
	localparam logic [7:0] ADDR_CLK_BASE = 8'h00;
	localparam logic [7:0] ADDR_CLK_SLOPE = 8'h04;
	localparam logic [7:0] ADDR_DUTY = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;

	// reset values
	localparam logic [15:0] CLK_BASE_RST = 16'h0019;
	localparam logic [7:0] CLK_SLOPE_RST = 8'h10;
	localparam logic [15:0] DUTY_RST = 16'h0008;

	// status field positions
	localparam int ST_NPH_LSB = 0;
	localparam int ST_DONE_BIT = 2;
	localparam int ST_MULTI_BIT = 3;
	localparam int ST_RPM_BIT = 4;
	localparam int ST_DCM_BIT = 5;
	localparam int ST_TRANS_BIT = 6;
	localparam int ST_STATE_LSB = 7;

	// slope product is scaled down by this shift
	localparam int SLOPE_SHIFT = 4;

	// sequencing states
	typedef enum logic [1:0]
	{
		ST_OFF = 2'b00,
		ST_RST = 2'b01,
		ST_DET = 2'b10,
		ST_RUN = 2'b11
	} mpw_state_t;

endpackage

// File: hdl/mpw_phase_chan.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// one phase channel: a pulse of programmable width per trigger
// ==========================================================================
module mpw_phase_chan #(
	parameter int DUTY_W = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// control
	input wire logic trig,
	input wire logic chan_en,
	input wire logic [DUTY_W-1:0] duty,
	// pulse
	output logic pwm_out
);

	logic [DUTY_W-1:0] cnt_r; // cycles of on-time left
	logic [DUTY_W-1:0] cnt_nxt;

	// retrigger reloads, so a duty at the period keeps the output high
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (!chan_en)
			cnt_nxt = '0;
		else if (trig)
			cnt_nxt = duty;
		else if (cnt_r != '0)
			cnt_nxt = cnt_r - 1'b1;
	end

	// each channel counts alone, so phases may overlap
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_r <= '0;
			pwm_out <= 1'b0;
		end
		else if (ce)
		begin
			cnt_r <= cnt_nxt;
			pwm_out <= (cnt_nxt != '0);
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_chan_trig_on: assert property (ce && chan_en && trig && duty != '0 |=> pwm_out)
		else $error("channel did not start its pulse");

endmodule
`default_nettype wire

// File: hdl/mpw_phase_ctrl.sv
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// - three phases default, tied pins shed
// - sink and compare phase two, three
// - detect over first three oscillator ticks
// - tied outputs high impedance after detection
// - phase outputs independent, may overlap
// - heavy load runs all phases PWM
// - light load runs phase one only
// - multiphase switching timed by master clock
// - ripple limit sets phase one high
// - ramp reaching compensation ends pulse
// - deeper sleep blocks reverse current
// - transient or current limit forces full
// - transient lasts the mask interval
// - per-phase frequency is master over count
// - master clock slows as voltage code falls
// - mask interval about one hundred microseconds
// - reset cycle precedes detection, then start
module mpw_phase_ctrl #(
	parameter int MASK_CYC = mpw_pkg::MASK_CYC_DEF,
	parameter int DUTY_W = 16
) (
	// clock, reset and freeze
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// controller enable and cpu load state
	input wire logic en_in,
	input wire logic power_state_in_n,
	input wire logic deeper_sleep_in,
	input wire logic [6:0] voltage_code,
	// analog comparator results
	input wire logic current_limit_in,
	input wire logic ripple_limit_set,
	input wire logic ramp_hit_in,
	input wire logic zero_cross_in,
	input wire logic window_ok_in,
	input wire logic phase_two_pin_high,
	input wire logic phase_three_pin_high,
	// phase pins
	output logic phase_one_out,
	output logic phase_one_oe,
	output logic phase_two_out,
	output logic phase_two_oe,
	output logic phase_two_sink,
	output logic phase_three_out,
	output logic phase_three_oe,
	output logic phase_three_sink,
	// other outputs
	output logic low_side_ctrl_n,
	output logic power_good_out,
	output logic soft_start_go
);
	import mpw_pkg::*;

	localparam int MW = $clog2(MASK_CYC + 1);
	localparam logic [11:0] RST_LAST = 12'(RESET_CYC - 1);
	localparam logic [1:0] DET_LAST = 2'(DETECT_TICKS - 1);

	// ======================================================================
	// address decode
	// ======================================================================
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// ======================================================================
	// declarations
	// ======================================================================
	mpw_state_t state_r; // sequencing state
	logic [11:0] rst_cnt_r; // internal reset cycle timer
	logic [1:0] det_ticks_r; // oscillator ticks seen in detection
	logic [1:0] nph_r; // latched phase count, 1 to 3
	logic [16:0] mclk_cnt_r; // master clock divider
	logic mtick_r; // one-cycle master clock tick
	logic [1:0] slot_r; // interleave slot
	logic [6:0] code_q_r; // last voltage code
	logic dslp_q_r; // last deeper-sleep level
	logic [MW-1:0] mask_cnt_r; // transient mask timer
	logic multi_r; // full-phase PWM mode
	logic rpm_r; // single-phase ripple mode
	logic dcm_r; // ripple mode from deeper sleep
	logic rpm_q_r; // ripple-mode pulse latch
	logic [15:0] clk_base_r; // master period base, cycles
	logic [7:0] clk_slope_r; // timing resistor scale
	logic [DUTY_W-1:0] duty_r; // on-time per pulse, cycles
	logic [14:0] slope_prod; // code-dependent period addend
	logic [16:0] mper; // master period
	logic code_chg; // code or sleep edge this cycle
	logic transient; // forced full-phase window
	logic multi_nxt;
	logic [2:0] ph_en; // phases in use
	logic [2:0] trig; // per-phase triggers
	logic [2:0] chan_out; // channel pulses
	logic apb_setup; // access phase, answer pending
	logic apb_wr; // write taking effect
	logic mapped;
	logic [6:0] code_inv; // code complement, kept at code width
	logic code_vld_r; // code compare primed after the first edge

	// ======================================================================
	// master clock: period grows as the code falls
	// ======================================================================
	// complement at seven bits first, so widening cannot bring in high ones
	assign code_inv = ~voltage_code;
	assign slope_prod = 15'(code_inv) * 15'(clk_slope_r);
	assign mper = {1'b0, clk_base_r} + {6'h00, slope_prod[14:SLOPE_SHIFT]};

	// runs once detection starts; a zero period still ticks every cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mclk_cnt_r <= 17'h00000;
			mtick_r <= 1'b0;
		end
		else if (ce)
		begin
			if (state_r == ST_DET || state_r == ST_RUN)
			begin
				if (mclk_cnt_r + 17'h00001 >= mper)
				begin
					mclk_cnt_r <= 17'h00000;
					mtick_r <= 1'b1;
				end
				else
				begin
					mclk_cnt_r <= mclk_cnt_r + 17'h00001;
					mtick_r <= 1'b0;
				end
			end
			else
			begin
				mclk_cnt_r <= 17'h00000;
				mtick_r <= 1'b0;
			end
		end
	end

	// ======================================================================
	// sequencer: reset cycle, detection, run
	// ======================================================================
	// enable low returns the state to off; the count is kept until redone
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= ST_OFF;
			rst_cnt_r <= 12'h000;
			det_ticks_r <= 2'h0;
			nph_r <= 2'h3;
		end
		else if (ce)
		begin
			if (!en_in)
				state_r <= ST_OFF;
			else
			begin
				case (state_r)
					ST_OFF:
					begin
						state_r <= ST_RST;
						rst_cnt_r <= 12'h000;
					end
					ST_RST:
					begin
						if (rst_cnt_r == RST_LAST)
						begin
							state_r <= ST_DET;
							det_ticks_r <= 2'h0;
						end
						else
							rst_cnt_r <= rst_cnt_r + 12'h001;
					end
					ST_DET:
					begin
						if (mtick_r)
						begin
							if (det_ticks_r == DET_LAST)
							begin
								state_r <= ST_RUN;
								if (phase_two_pin_high)
									nph_r <= 2'h1;
								else if (phase_three_pin_high)
									nph_r <= 2'h2;
								else
									nph_r <= 2'h3;
							end
							else
								det_ticks_r <= det_ticks_r + 2'h1;
						end
					end
					ST_RUN:
						state_r <= ST_RUN;
					default:
						state_r <= ST_OFF;
				endcase
			end
		end
	end

	// ======================================================================
	// transient window and mode choice
	// ======================================================================
	// the first edge only primes the compare, so reset is not taken for a code step
	assign code_chg = code_vld_r
		&& ((voltage_code != code_q_r) || (deeper_sleep_in != dslp_q_r));
	assign transient = code_chg || (mask_cnt_r != '0);
	// forced full phase outranks both load-state inputs
	assign multi_nxt = transient || current_limit_in
		|| (power_state_in_n && !deeper_sleep_in);

	// mask timer restarts on every code or sleep edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			code_q_r <= 7'h00;
			dslp_q_r <= 1'b0;
			mask_cnt_r <= '0;
			code_vld_r <= 1'b0;
		end
		else if (ce)
		begin
			code_vld_r <= 1'b1;
			code_q_r <= voltage_code;
			dslp_q_r <= deeper_sleep_in;
			if (code_chg)
				mask_cnt_r <= MW'(MASK_CYC);
			else if (mask_cnt_r != '0)
				mask_cnt_r <= mask_cnt_r - 1'b1;
		end
	end

	// registered mode bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			multi_r <= 1'b1;
			rpm_r <= 1'b0;
			dcm_r <= 1'b0;
		end
		else if (ce)
		begin
			multi_r <= multi_nxt;
			rpm_r <= !multi_nxt;
			dcm_r <= !multi_nxt && deeper_sleep_in;
		end
	end

	// ripple latch: the set comparator raises it, the ramp ends it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rpm_q_r <= 1'b0;
		else if (ce)
		begin
			if (!rpm_r || state_r != ST_RUN)
				rpm_q_r <= 1'b0;
			else if (rpm_q_r)
				rpm_q_r <= !ramp_hit_in;
			else
				rpm_q_r <= ripple_limit_set;
		end
	end

	// ======================================================================
	// interleave: slots rotate over the phases in use
	// ======================================================================
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			slot_r <= 2'h0;
		else if (ce)
		begin
			if (state_r != ST_RUN)
				slot_r <= 2'h0;
			else if (mtick_r)
				slot_r <= (slot_r + 2'h1 >= nph_r) ? 2'h0 : slot_r + 2'h1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_chan
			assign ph_en[gi] = (2'(gi) < nph_r);
			// one trigger per master tick, so each phase runs at tick over count
			assign trig[gi] = mtick_r && (slot_r == 2'(gi)) && multi_r && ph_en[gi];
			mpw_phase_chan #(
				.DUTY_W(DUTY_W)
			) u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.trig(trig[gi]),
				.chan_en(ph_en[gi] && state_r == ST_RUN),
				.duty(duty_r),
				.pwm_out(chan_out[gi])
			);
		end
	endgenerate

	// ======================================================================
	// pin drivers
	// ======================================================================
	// tied pins are released so the pull-up keeps them high
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_one_out <= 1'b0;
			phase_one_oe <= 1'b0;
			phase_two_out <= 1'b0;
			phase_two_oe <= 1'b0;
			phase_two_sink <= 1'b0;
			phase_three_out <= 1'b0;
			phase_three_oe <= 1'b0;
			phase_three_sink <= 1'b0;
			low_side_ctrl_n <= 1'b1;
			power_good_out <= 1'b0;
			soft_start_go <= 1'b0;
		end
		else if (ce)
		begin
			phase_one_out <= multi_r ? chan_out[0] : rpm_q_r;
			phase_one_oe <= (state_r == ST_RUN);
			phase_two_out <= multi_r && chan_out[1];
			phase_two_oe <= (state_r == ST_RUN) && ph_en[1];
			phase_two_sink <= (state_r == ST_DET);
			phase_three_out <= multi_r && chan_out[2];
			phase_three_oe <= (state_r == ST_RUN) && ph_en[2];
			phase_three_sink <= (state_r == ST_DET);
			low_side_ctrl_n <= !(dcm_r && zero_cross_in);
			power_good_out <= (state_r == ST_RUN) && window_ok_in && !transient;
			soft_start_go <= (state_r == ST_RUN);
		end
	end

	// ======================================================================
	// apb slave: answer one cycle into the access phase
	// ======================================================================
	assign apb_setup = psel && penable && !pready;
	assign apb_wr = psel && penable && pready && pwrite;
	assign mapped = hit(paddr, ADDR_CLK_BASE) || hit(paddr, ADDR_CLK_SLOPE)
		|| hit(paddr, ADDR_DUTY) || hit(paddr, ADDR_STATUS);

	// read data and error are captured together with ready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else if (ce)
		begin
			pready <= apb_setup;
			pslverr <= apb_setup && !mapped;
			prdata <= 32'h00000000;
			if (apb_setup && !pwrite)
			begin
				if (hit(paddr, ADDR_CLK_BASE))
					prdata <= {16'h0000, clk_base_r};
				else if (hit(paddr, ADDR_CLK_SLOPE))
					prdata <= {24'h000000, clk_slope_r};
				else if (hit(paddr, ADDR_DUTY))
					prdata <= 32'(duty_r);
				else if (hit(paddr, ADDR_STATUS))
				begin
					prdata[ST_NPH_LSB +: 2] <= nph_r;
					prdata[ST_DONE_BIT] <= (state_r == ST_RUN);
					prdata[ST_MULTI_BIT] <= multi_r;
					prdata[ST_RPM_BIT] <= rpm_r;
					prdata[ST_DCM_BIT] <= dcm_r;
					prdata[ST_TRANS_BIT] <= transient;
					prdata[ST_STATE_LSB +: 2] <= state_r;
				end
			end
		end
	end

	// writes land only at the edge that completes the access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_base_r <= CLK_BASE_RST;
			clk_slope_r <= CLK_SLOPE_RST;
			duty_r <= DUTY_W'(DUTY_RST);
		end
		else if (ce && apb_wr)
		begin
			if (hit(paddr, ADDR_CLK_BASE))
				clk_base_r <= pwdata[15:0];
			if (hit(paddr, ADDR_CLK_SLOPE))
				clk_slope_r <= pwdata[7:0];
			if (hit(paddr, ADDR_DUTY))
				duty_r <= pwdata[DUTY_W-1:0];
		end
	end

	// ======================================================================
	// checks
	// ======================================================================
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_det_end;
		ce && en_in && state_r == ST_DET && mtick_r && det_ticks_r == DET_LAST;
	endsequence

	sequence s_rpm_rise;
		ce && rpm_r && state_r == ST_RUN && !rpm_q_r && ripple_limit_set;
	endsequence

	a_det_three_ticks: assert property (s_det_end |=> state_r == ST_RUN)
		else $error("detection did not end on its third tick");
	a_det_sink_on: assert property (ce && state_r == ST_DET |=> phase_two_sink && phase_three_sink)
		else $error("detection sink not applied");
	a_count_two: assert property ((s_det_end and (!phase_two_pin_high && phase_three_pin_high))
		|=> nph_r == 2'h2)
		else $error("two-phase strap not latched");
	a_tied_hiz: assert property (ce && state_r == ST_RUN && nph_r != 2'h3 |=> !phase_three_oe)
		else $error("tied phase still driven");
	a_full_mode: assert property (ce && power_state_in_n && !deeper_sleep_in |=> multi_r)
		else $error("heavy load did not select full phase");
	a_shed_phases: assert property (ce && !multi_r |=> !phase_two_out && !phase_three_out)
		else $error("shed phase switched");
	a_force_full: assert property (ce && (current_limit_in || code_chg) |=> multi_r)
		else $error("forced full phase missed");
	a_mask_len: assert property (ce && code_chg |=> mask_cnt_r == MW'(MASK_CYC) && !power_good_out)
		else $error("mask interval not restarted");
	a_rpm_pulse: assert property (s_rpm_rise ##1 (ce && !multi_r) |=> phase_one_out)
		else $error("ripple set did not raise phase one");
	a_rpm_end: assert property (ce && rpm_q_r && ramp_hit_in |=> !rpm_q_r)
		else $error("ramp did not end the pulse");
	a_dcm_block: assert property (ce && dcm_r && zero_cross_in |=> !low_side_ctrl_n)
		else $error("reverse current not blocked");
	a_slot_wrap: assert property (ce && state_r == ST_RUN && mtick_r && slot_r + 2'h1 >= nph_r
		|=> slot_r == 2'h0)
		else $error("interleave slot did not wrap");
	a_reset_hold: assert property (ce && en_in && state_r == ST_RST && rst_cnt_r != RST_LAST
		|=> state_r == ST_RST)
		else $error("reset cycle cut short");

endmodule
`default_nettype wire

// File: testbench/mpw_gate_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// far side: board straps, pin comparators and gate drivers counting pulses
// ==========================================================================
module mpw_gate_model (
	// clock
	input wire logic pclk,
	// board straps: pin tied to the supply rail
	input wire logic tie2,
	input wire logic tie3,
	// pin drive from the controller
	input wire logic p1,
	input wire logic p1_oe,
	input wire logic p2,
	input wire logic p2_oe,
	input wire logic p2_sink,
	input wire logic p3,
	input wire logic p3_oe,
	input wire logic p3_sink,
	// comparator results back to the controller
	output logic pin2_hi,
	output logic pin3_hi,
	// pulses seen by each gate driver
	output int cnt1,
	output int cnt2,
	output int cnt3
);
	logic flip; // an undriven pin wanders, so a stale level never passes
	logic [2:0] prev; // driven levels one cycle back
	logic [2:0] cur;
	assign cur = {p3 & p3_oe, p2 & p2_oe, p1 & p1_oe};
	// strap wins, then the driver, then the sink pulls the pin low
	assign pin2_hi = tie2 ? 1'h1 : (p2_oe ? p2 : (p2_sink ? 1'h0 : flip));
	assign pin3_hi = tie3 ? 1'h1 : (p3_oe ? p3 : (p3_sink ? 1'h0 : flip));
	initial
	begin
		flip = 1'h0;
		prev = 3'h0;
		cnt1 = 0;
		cnt2 = 0;
		cnt3 = 0;
	end
	// count rising edges of each driven pin
	always @(posedge pclk)
	begin
		flip <= ~flip;
		prev <= cur;
		cnt1 <= cnt1 + int'(cur[0] & ~prev[0]);
		cnt2 <= cnt2 + int'(cur[1] & ~prev[1]);
		cnt3 <= cnt3 + int'(cur[2] & ~prev[2]);
	end
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// bench for the phase and mode controller
// ==========================================================================
module tb;
	import mpw_pkg::*;
	localparam int MASK = 20; // short mask window keeps the run brief
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err;
	logic en_in = 1'h0, psi_n = 1'h1, dsl = 1'h0, cur_lim = 1'h0;
	logic rip = 1'h0, ramp = 1'h0, zc = 1'h0, tie2 = 1'h0, tie3 = 1'h0, ov;
	logic [6:0] vcode = 7'h7f; // all ones gives no slope term
	logic p1, p1_oe, p2, p2_oe, p2_sink, p3, p3_oe, p3_sink;
	logic lsc_n, pgood, ss_go, pin2_hi, pin3_hi;
	int cnt1, cnt2, cnt3, c1, c2, c3, n, k, e2, e3;
	int miscompares = 0, n_compared = 0;
	// ==========================================================================
	// design and far side
	// ==========================================================================
	mpw_phase_ctrl #(.MASK_CYC(MASK)) i_dut (.pclk(pclk), .presetn(presetn), .ce(1'h1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .en_in(en_in),
		.power_state_in_n(psi_n), .deeper_sleep_in(dsl), .voltage_code(vcode),
		.current_limit_in(cur_lim), .ripple_limit_set(rip), .ramp_hit_in(ramp),
		.zero_cross_in(zc), .window_ok_in(1'h1), .phase_two_pin_high(pin2_hi),
		.phase_three_pin_high(pin3_hi), .phase_one_out(p1), .phase_one_oe(p1_oe),
		.phase_two_out(p2), .phase_two_oe(p2_oe), .phase_two_sink(p2_sink),
		.phase_three_out(p3), .phase_three_oe(p3_oe), .phase_three_sink(p3_sink),
		.low_side_ctrl_n(lsc_n), .power_good_out(pgood), .soft_start_go(ss_go));
	mpw_gate_model i_gate (.pclk(pclk), .tie2(tie2), .tie3(tie3), .p1(p1), .p1_oe(p1_oe),
		.p2(p2), .p2_oe(p2_oe), .p2_sink(p2_sink), .p3(p3), .p3_oe(p3_oe),
		.p3_sink(p3_sink), .pin2_hi(pin2_hi), .pin3_hi(pin3_hi), .cnt1(cnt1),
		.cnt2(cnt2), .cnt3(cnt3));
	always #10 pclk = ~pclk;
	// ==========================================================================
	// helpers
	// ==========================================================================
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask
	// one apb transfer; entered just after a rising edge, leaves one idle cycle
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int w;
		w = 0;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
		begin
			@(posedge pclk);
			w++;
		end
		while (pready !== 1'h1 && w < 50);
		rd = prdata;
		err = pslverr;
		chk("apb answer", pready, 1'h1);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	// bounded wait for a level; the bound only guards against a hang
	task automatic wait_lvl(ref logic s, input logic v, input int lim, input string nm);
		int w;
		w = 0;
		while (s !== v && w < lim)
		begin
			@(posedge pclk);
			w++;
		end
		chk(nm, s, v);
	endtask
	// enable with given straps and walk through reset cycle and detection
	task bring_up(input logic t2, input logic t3);
		en_in <= 1'h0;
		tie2 <= t2;
		tie3 <= t3;
		cyc(2);
		en_in <= 1'h1;
		cyc(2000);
		chk("start early", ss_go, 1'h0);
		wait_lvl(p2_sink, 1'h1, 1000, "sink two");
		chk("sink three", p3_sink, 1'h1);
		wait_lvl(ss_go, 1'h1, 200, "start go");
		cyc(2);
		chk("sinks off", {p2_sink, p3_sink}, 2'h0);
	endtask
	task test_done;
		if (miscompares == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================================================
	// watchdog: the tests need well under a third of this span
	// ==========================================================================
	initial
	begin
		#1000000;
		miscompares++;
		test_done();
	end
	// ==========================================================================
	// main sequence
	// ==========================================================================
	initial
	begin
		cyc(4);
		presetn <= 1'h1;
		apb(1'h0, ADDR_CLK_BASE, 32'h0);
		chk("base reset", rd, {16'h0, CLK_BASE_RST});
		apb(1'h0, 8'h10, 32'h0);
		chk("unmapped", err, 1'h1);
		apb(1'h1, ADDR_CLK_BASE, 32'ha); // master period of ten cycles
		// each phase count, heavy load: rate per phase is master over count
		for (int cfg = 0; cfg < 3; cfg++)
		begin
			bring_up(cfg == 2, cfg >= 1);
			n = 3 - cfg;
			apb(1'h0, ADDR_STATUS, 32'h0);
			chk("phase count", rd[1:0], n[1:0]);
			chk("oe two", p2_oe, cfg < 2);
			chk("oe three", p3_oe, cfg < 1);
			apb(1'h1, ADDR_DUTY, (n == 3) ? 32'hf : 32'h4);
			cyc(10);
			c1 = cnt1;
			c2 = cnt2;
			c3 = cnt3;
			ov = 1'h0;
			repeat (300)
			begin
				@(posedge pclk);
				ov = ov | (p1 & p2 & p2_oe);
			end
			e2 = (cfg < 2) ? 30 / n : 0;
			e3 = (cfg < 1) ? 10 : 0;
			chk("rate one", (cnt1 - c1) inside {[30 / n - 1:30 / n + 1]}, 1'h1);
			chk("rate two", (cnt2 - c2) inside {[e2 - 1:e2 + 1]}, 1'h1);
			chk("rate three", (cnt3 - c3) inside {[e3 - 1:e3 + 1]}, 1'h1);
			if (n == 3)
				chk("overlap", ov, 1'h1);
		end
		// straps removed after detection: count must hold
		tie2 <= 1'h0;
		tie3 <= 1'h0;
		cyc(5);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("count held", rd[1:0], 2'h1);
		bring_up(1'h0, 1'h0);
		apb(1'h1, ADDR_DUTY, 32'h4);
		// light load: phase one alone, ripple triggered
		psi_n <= 1'h0;
		cyc(5);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("light mode", rd[4:3], 2'h2);
		c2 = cnt2;
		c3 = cnt3;
		rip <= 1'h1;
		@(posedge pclk);
		rip <= 1'h0;
		wait_lvl(p1, 1'h1, 5, "ripple set");
		cyc(5);
		chk("pulse held", p1, 1'h1);
		ramp <= 1'h1;
		@(posedge pclk);
		ramp <= 1'h0;
		wait_lvl(p1, 1'h0, 5, "ramp end");
		chk("shed", cnt2 - c2 + cnt3 - c3, 32'h0);
		// current limit forces full phase
		cur_lim <= 1'h1;
		cyc(3);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("limit full", rd[4:3], 2'h1);
		cur_lim <= 1'h0;
		// deeper sleep: transient first, then ripple with reverse blocking
		dsl <= 1'h1;
		cyc(2);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("sleep transient", rd[6], 1'h1);
		cyc(MASK + 5);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk("sleep mode", rd[6:4], 3'h3);
		zc <= 1'h1;
		cyc(3);
		chk("reverse block", lsc_n, 1'h0);
		zc <= 1'h0;
		dsl <= 1'h0;
		psi_n <= 1'h1;
		cyc(MASK + 5);
		// code change: power good masked for the transient window
		chk("good before", pgood, 1'h1);
		vcode <= 7'h6f;
		k = 0;
		repeat (MASK + 10)
		begin
			@(posedge pclk);
			k += int'(pgood === 1'h0);
		end
		chk("mask length", k, MASK + 1);
		// lower code, longer master period, fewer pulses
		c1 = cnt1;
		cyc(300);
		chk("slower clock", (cnt1 - c1) < 6, 1'h1);
		test_done();
	end
endmodule
`default_nettype wire
